// >>> verilog/sac_pkg.sv
`default_nettype none
package sac_pkg;

  // Width of one result word, in two's complement.
  localparam int RES_BITS = 14;

  // Serial clock rising edges in one frame; acquisition starts on the last.
  localparam logic [4:0] FRAME_EDGES   = 5'h10;
  // Rising edge on which the last result bit leaves and the pin floats.
  localparam logic [4:0] LAST_BIT_EDGE = 5'h0E;
  localparam logic [4:0] EDGE_ONE      = 5'h01;
  localparam logic [4:0] EDGE_ZERO     = 5'h00;

  // Strobe pulses with no serial clock edge between them.
  localparam logic [2:0] NAP_PULSES    = 3'h2;
  localparam logic [2:0] SLEEP_PULSES  = 3'h4;
  localparam logic [2:0] PULSE_ONE     = 3'h1;
  localparam logic [2:0] PULSE_ZERO    = 3'h0;

  // Gray codes along active, nap, sleep.
  typedef enum logic [1:0] {
    SAC_PWR_ACTIVE = 2'h0,
    SAC_PWR_NAP    = 2'h1,
    SAC_PWR_SLEEP  = 2'h3
  } sac_power_e;

  typedef logic [RES_BITS-1:0] sac_word_t;

  localparam sac_word_t WORD_RESET = 14'h0000;

  // Rising edges seen on the two host pins, one-cycle pulses.
  typedef struct packed {
    logic sck_rise;
    logic convert_strobe_rise;
  } sac_pin_ev_s;

endpackage : sac_pkg
`default_nettype wire

// >>> verilog/sac_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sac_pin_sync
  import sac_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        serial_clk,
  input  wire logic        convert_strobe,
  output var sac_pin_ev_s  pin_ev
);

  logic [1:0] pin_raw;
  logic [1:0] meta_q;
  logic [1:0] meta_d;
  logic [1:0] sync_q;
  logic [1:0] sync_d;
  logic [1:0] last_q;
  logic [1:0] last_d;

  assign pin_raw = {serial_clk, convert_strobe};

  // Two flops per pin, then a third for edge detection; only the second
  // flop and the third are compared, so the metastable stage is never read.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      always_comb begin
        meta_d[gi] = pin_raw[gi];
        sync_d[gi] = meta_q[gi];
        last_d[gi] = sync_q[gi];
      end

      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
          last_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= meta_d[gi];
          sync_q[gi] <= sync_d[gi];
          last_q[gi] <= last_d[gi];
        end
      end
    end
  endgenerate

  // Rising edges as one-cycle pulses.
  // One assignment drives the whole struct, so it has a single driver.
  assign pin_ev = {sync_q[1] & ~last_q[1], sync_q[0] & ~last_q[0]};

endmodule : sac_pin_sync
`default_nettype wire

// >>> verilog/sac_convert_strobe_port.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: The result pin is driven only while a result bit is shown, else floats.
// R2: The word shifted out is the sample caught at the previous strobe.
// R3: Result words are sent in two's complement, most significant bit first.
// R4: Each serial clock rising edge advances the frame and shows the next bit; the code drops an edge that comes in the same cycle as a strobe rise.
// R5: A strobe rising edge freezes the input sample and starts a conversion.
// R6: Two strobe pulses with no serial clock edge between put it in nap.
// R7: Four or more strobe pulses with no clock edge put it in sleep.
// R8: One or more serial clock rising edges wake the device from sleep.
// R9: Acquisition runs from the sixteenth clock edge to the next strobe.
// R10: After reset the device is active and ready to convert at once.
// R11: After a wake from nap the very next strobe starts a real conversion.
// R12: Any serial clock rising edge clears the strobe pulse count.
module sac_convert_strobe_port
  import sac_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        serial_clk,
  input  wire logic        convert_strobe,
  input  wire sac_word_t   sample_in,
  output logic             serial_result_out,
  output logic             serial_result_oe,
  output var sac_power_e   power_state,
  output logic             acquiring
);

  sac_pin_ev_s pin_ev;
  logic        sck_rise;
  logic        convert_strobe_rise;

  // The host clock is far slower than ref_clk, so sampling it is safe.
  sac_pin_sync u_pin_sync (
    .ref_clk        (ref_clk),
    .reset_n        (reset_n),
    .serial_clk     (serial_clk),
    .convert_strobe (convert_strobe),
    .pin_ev         (pin_ev)
  );

  assign sck_rise  = pin_ev.sck_rise;
  assign convert_strobe_rise = pin_ev.convert_strobe_rise;

  // ---- Power state ----
  sac_power_e pwr_q;
  sac_power_e pwr_d;
  logic [2:0] pulse_cnt_q;
  logic [2:0] pulse_cnt_d;
  logic [2:0] pulse_base;

  // A clock edge clears the count first, so a strobe in the same cycle
  // counts as the first pulse of a new run.
  always_comb begin
    pulse_base  = sck_rise ? PULSE_ZERO : pulse_cnt_q; // R12
    pulse_cnt_d = pulse_base;
    pwr_d       = sck_rise ? SAC_PWR_ACTIVE : pwr_q; // R8
    if (convert_strobe_rise && pulse_base != SLEEP_PULSES) begin
      pulse_cnt_d = pulse_base + PULSE_ONE;
    end
    if (convert_strobe_rise) begin
      if (pulse_cnt_d == SLEEP_PULSES) begin
        pwr_d = SAC_PWR_SLEEP; // R7
      end else if (pulse_cnt_d == NAP_PULSES) begin
        pwr_d = SAC_PWR_NAP; // R6
      end
    end
  end

  // Reset stands in for power-up, which lands in the active state.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_q       <= SAC_PWR_ACTIVE; // R10
      pulse_cnt_q <= PULSE_ZERO;
    end else begin
      pwr_q       <= pwr_d;
      pulse_cnt_q <= pulse_cnt_d;
    end
  end

  // ---- Conversion frame ----
  sac_word_t  held_q;
  sac_word_t  held_d;
  sac_word_t  shift_q;
  sac_word_t  shift_d;
  logic [4:0] edge_cnt_q;
  logic [4:0] edge_cnt_d;
  logic [4:0] edge_next;
  logic       oe_q;
  logic       oe_d;
  logic       dout_q;
  logic       dout_d;
  logic       acq_q;
  logic       acq_d;

  // The strobe has priority over a clock edge in the same cycle: losing a
  // conversion start is worse than losing one bit of a frame.
  always_comb begin
    held_d     = held_q;
    shift_d    = shift_q;
    edge_cnt_d = edge_cnt_q;
    oe_d       = oe_q;
    dout_d     = dout_q;
    acq_d      = acq_q;
    edge_next  = edge_cnt_q + EDGE_ONE;
    if (convert_strobe_rise) begin // R11
      held_d     = sample_in; // R5
      shift_d    = held_q; // R2
      edge_cnt_d = EDGE_ZERO;
      oe_d       = 1'b1; // R1
      dout_d     = held_q[RES_BITS-1]; // R3
      acq_d      = 1'b0; // R9
    end else if (sck_rise && edge_cnt_q != FRAME_EDGES) begin
      edge_cnt_d = edge_next; // R4
      shift_d    = {shift_q[RES_BITS-2:0], 1'b0};
      dout_d     = shift_q[RES_BITS-2]; // R4
      if (edge_next == LAST_BIT_EDGE) begin
        oe_d   = 1'b0; // R1
        dout_d = 1'b0;
      end
      if (edge_next == FRAME_EDGES) begin
        acq_d = 1'b1; // R9
      end
    end
  end

  // Before the first strobe the frame counter sits at its end, so idle
  // clocks neither drive the pin nor disturb acquisition.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      held_q     <= WORD_RESET;
      shift_q    <= WORD_RESET;
      edge_cnt_q <= FRAME_EDGES;
      oe_q       <= 1'b0;
      dout_q     <= 1'b0;
      acq_q      <= 1'b1;
    end else begin
      held_q     <= held_d;
      shift_q    <= shift_d;
      edge_cnt_q <= edge_cnt_d;
      oe_q       <= oe_d;
      dout_q     <= dout_d;
      acq_q      <= acq_d;
    end
  end

  // Outputs come straight from flops.
  assign serial_result_out = dout_q;
  assign serial_result_oe  = oe_q;
  assign power_state       = pwr_q;
  assign acquiring         = acq_q;

  // ---- Checks ----
  logic held_msb;
  logic shift_next_bit;

  assign held_msb       = held_q[RES_BITS-1];
  assign shift_next_bit = shift_q[RES_BITS-2];

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  property p_pin_floats;
    sck_rise && !convert_strobe_rise && edge_cnt_q == LAST_BIT_EDGE - EDGE_ONE
      |=> !serial_result_oe [*1] ##1 (convert_strobe_rise || !serial_result_oe);
  endproperty
  a_pin_floats: assert property (p_pin_floats) // R1
    else $error("result pin still driven after last bit");

  property p_prev_word;
    convert_strobe_rise |=> serial_result_oe && serial_result_out == $past(held_msb);
  endproperty
  a_prev_word: assert property (p_prev_word) // R2
    else $error("first bit is not the previous sample msb");

  property p_freeze;
    convert_strobe_rise |=> held_q == $past(sample_in);
  endproperty
  a_freeze: assert property (p_freeze) // R5
    else $error("sample not frozen on strobe");

  property p_advance;
    sck_rise && !convert_strobe_rise && serial_result_oe
      && edge_cnt_q < LAST_BIT_EDGE - EDGE_ONE
      |=> serial_result_out == $past(shift_next_bit) && serial_result_oe;
  endproperty
  a_advance: assert property (p_advance) // R4
    else $error("clock edge did not present next bit");

  property p_nap;
    convert_strobe_rise && !sck_rise && pulse_cnt_q == NAP_PULSES - PULSE_ONE
      |=> power_state == SAC_PWR_NAP;
  endproperty
  a_nap: assert property (p_nap) // R6
    else $error("second strobe did not enter nap");

  property p_sleep;
    convert_strobe_rise && !sck_rise && pulse_cnt_q >= SLEEP_PULSES - PULSE_ONE
      |=> power_state == SAC_PWR_SLEEP;
  endproperty
  a_sleep: assert property (p_sleep) // R7
    else $error("fourth strobe did not enter sleep");

  property p_wake;
    sck_rise |=> power_state == SAC_PWR_ACTIVE;
  endproperty
  a_wake: assert property (p_wake) // R8
    else $error("clock edge did not wake device");

  property p_acq;
    sck_rise && !convert_strobe_rise && edge_cnt_q == FRAME_EDGES - EDGE_ONE
      |=> acquiring;
  endproperty
  a_acq: assert property (p_acq) // R9
    else $error("acquisition did not start on frame end");

  property p_acq_end;
    convert_strobe_rise |=> !acquiring;
  endproperty
  a_acq_end: assert property (p_acq_end) // R9
    else $error("acquisition not ended by strobe");

  property p_powerup;
    $rose(reset_n) |-> power_state == SAC_PWR_ACTIVE;
  endproperty
  a_powerup: assert property (p_powerup) // R10
    else $error("not active after reset");

  property p_nap_wake_convert_strobe;
    (sck_rise && power_state == SAC_PWR_NAP) ##[1:16] convert_strobe_rise
      |=> serial_result_oe && edge_cnt_q == EDGE_ZERO;
  endproperty
  a_nap_wake_convert_strobe: assert property (p_nap_wake_convert_strobe) // R11
    else $error("strobe after nap wake did not start conversion");

  property p_cnt_clear;
    sck_rise && !convert_strobe_rise |=> pulse_cnt_q == PULSE_ZERO;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) // R12
    else $error("clock edge did not clear pulse count");

  c_nap:   cover property (power_state == SAC_PWR_NAP);
  c_sleep: cover property (power_state == SAC_PWR_SLEEP);
  c_frame: cover property ($rose(acquiring));
  c_wake:  cover property (power_state == SAC_PWR_SLEEP ##1 sck_rise);

endmodule : sac_convert_strobe_port
`default_nettype wire

// >>> sim/sac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sac_host_model (
  input  wire logic ref_clk,
  output logic      serial_clk,
  output logic      convert_strobe
);
  // Both pins idle low; the serial clock stands still outside its pulses.
  initial begin
    serial_clk = 1'b0;
    convert_strobe = 1'b0;
  end
  // One pin pulse, 4 cycles high (half of 160 ns), then low for gap cycles.
  // A gap of 4 or more keeps each level long enough for the synchronisers.
  task automatic pulse(input logic strobe, input int gap);
    @(posedge ref_clk);
    if (strobe) begin
      convert_strobe <= 1'b1;
    end else begin
      serial_clk <= 1'b1;
    end
    repeat (4) @(posedge ref_clk);
    convert_strobe <= 1'b0;
    serial_clk <= 1'b0;
    repeat (gap) @(posedge ref_clk);
  endtask : pulse
  // Both pins rise together, so the design sees both edges in one cycle.
  task automatic pulse_both(input int gap);
    @(posedge ref_clk);
    convert_strobe <= 1'b1;
    serial_clk <= 1'b1;
    repeat (4) @(posedge ref_clk);
    convert_strobe <= 1'b0;
    serial_clk <= 1'b0;
    repeat (gap) @(posedge ref_clk);
  endtask : pulse_both
endmodule : sac_host_model
`default_nettype wire

// >>> sim/serial_adc_conversion_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module serial_adc_conversion_port_test;
  import sac_pkg::*;
  logic       ref_clk;
  logic       reset_n;
  wire        serial_clk;
  wire        convert_strobe;
  sac_word_t  sample_in;
  sac_word_t  sent;
  logic       sro;
  logic       soe;
  logic       acq;
  sac_power_e pwr;
  int         n_mismatch;
  int         n_compared;
  int         cycles;

  sac_convert_strobe_port sac_convert_strobe_port_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .serial_clk(serial_clk),
    .convert_strobe(convert_strobe), .sample_in(sample_in),
    .serial_result_out(sro), .serial_result_oe(soe),
    .power_state(pwr), .acquiring(acq)
  );
  sac_host_model sac_host_model_i (
    .ref_clk(ref_clk), .serial_clk(serial_clk),
    .convert_strobe(convert_strobe)
  );

  // Free-running 50 MHz system clock.
  always #10 ref_clk = ~ref_clk;

  // Hang guard; the whole run needs far fewer cycles than this.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // Bit shown after k serial clock rises: most significant bit first.
  function automatic logic exp_bit(input sac_word_t w, input int k);
    return w[RES_BITS-1-k];
  endfunction : exp_bit

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : chk_bit

  task automatic chk_pwr(input sac_power_e got, input sac_power_e exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t power state", $time);
    end
  endtask : chk_pwr

  // One full frame: strobe, then 16 clock rises with a random gap.
  task automatic frame(input sac_word_t w);
    sample_in <= w;
    sac_host_model_i.pulse(1'b1, 4 + $urandom_range(3));
    chk_bit(soe, 1'b1, "pin not driven after strobe");
    chk_bit(sro, exp_bit(sent, 0), "first result bit");
    chk_bit(acq, 1'b0, "acquiring during conversion");
    for (int k = 1; k <= 16; k++) begin
      sac_host_model_i.pulse(1'b0, 4 + $urandom_range(3));
      if (k < RES_BITS) begin
        chk_bit(sro, exp_bit(sent, k), "result bit");
      end else begin
        chk_bit(soe, 1'b0, "pin not floating");
      end
      chk_bit(acq, k == 16, "acquiring flag");
    end
    sent = w;
  endtask : frame

  // A run of strobes with the serial clock still; sample_in is held.
  task automatic strobes(input int n, input sac_power_e exp);
    repeat (n) sac_host_model_i.pulse(1'b1, 4);
    chk_pwr(pwr, exp);
    sent = sample_in;
  endtask : strobes

  task automatic wake();
    sac_host_model_i.pulse(1'b0, 4);
    chk_pwr(pwr, SAC_PWR_ACTIVE);
  endtask : wake

  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // Main sequence: reset state, frames with corner words, power modes.
  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    sample_in = WORD_RESET;
    sent = WORD_RESET;
    n_mismatch = 0;
    n_compared = 0;
    cycles = 0;
    void'($urandom(64));
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk_pwr(pwr, SAC_PWR_ACTIVE);
    chk_bit(soe, 1'b0, "pin driven after reset");
    chk_bit(acq, 1'b1, "acquiring after reset");
    frame(14'h2000);
    frame(14'h1FFF);
    frame(14'h3FFF);
    repeat (3) frame(sac_word_t'($urandom));
    strobes(2, SAC_PWR_NAP);
    wake();
    strobes(1, SAC_PWR_ACTIVE);
    wake();
    strobes(1, SAC_PWR_ACTIVE);
    strobes(1, SAC_PWR_NAP);
    strobes(1, SAC_PWR_NAP);
    strobes(1, SAC_PWR_SLEEP);
    strobes(2, SAC_PWR_SLEEP);
    wake();
    frame(sac_word_t'($urandom));
    sac_host_model_i.pulse_both(4);
    chk_bit(soe, 1'b1, "strobe lost to clock edge");
    chk_bit(acq, 1'b0, "acquiring after joint edge");
    chk_pwr(pwr, SAC_PWR_ACTIVE);
    strobes(1, SAC_PWR_NAP);
    wake();
    frame(sac_word_t'($urandom));
    complete_run();
  end
endmodule : serial_adc_conversion_port_test
`default_nettype wire
